// >>> asp_pkg.sv
// Purpose: Shared constants and types for the sampling converter port
// Assumes: System clock of 100 MHz
// Notes: Times kept in their own unit, cycle counts derived from them
package asp_pkg;
  localparam int DATA_W = 8;
  localparam int AIN_W = 10;
  localparam int LATENCY = 5;
  localparam int WARM_CYCLES = 20;
  localparam int FIFO_DEPTH = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STOP_TIME_NS = 100000;
  // Longest idle time, rounded down
  localparam int STOP_CYCLES = STOP_TIME_NS / CLK_PERIOD_NS;
  localparam logic [DATA_W-1:0] CODE_MIN = 8'h00;
  localparam logic [DATA_W-1:0] CODE_MAX = 8'hff;
  localparam logic [DATA_W-1:0] CODE_MID = 8'h80;
  localparam logic signed [AIN_W-1:0] AIN_NEG_FS = -10'sd128;
  localparam logic signed [AIN_W-1:0] AIN_POS_FS = 10'sd127;

  typedef struct packed {
    logic range_exceeded_flag;
    logic [DATA_W-1:0] code;
  } asp_result_t;
endpackage

// >>> asp_fifo.sv
// Purpose: Small flip-flop FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-low reset
// Notes: Full and empty come from an occupancy count
`timescale 1ns/100ps
module asp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] in_data, // Word to store
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  output logic [WIDTH-1:0] out_data, // Oldest word
  output logic out_valid, // Oldest word present
  input wire logic out_ready // Drain accepts
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == LAST_IDX) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = (cnt_reg != FULL_CNT);
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= bump(wr_reg);
      end
      if (pop) begin
        rd_reg <= bump(rd_reg);
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// >>> asp_sample_port.sv
// Purpose: Clocked digital side of an 8-bit pipelined sampling converter
// Assumes: Conversion clock and power-down arrive as asynchronous pins
// Notes: Analog difference is given as a signed count, one count per code step
// Operation
// - While the conversion clock is high, the input difference is tracked.
// - Each falling edge captures the tracked difference and starts its conversion.
// - A result appears at the fifth falling edge after sampling, held until next.
// - Every falling edge launches a new conversion, one result per period.
// - After power-up or a clock stop over 100us, data invalid for 20 cycles.
// - Power-down low turns off amplifiers and bias, no conversions meanwhile.
// - In power-down, data and flag outputs stay driven.
// - Leaving power-down needs input high plus 20 cycles before data is valid.
// - Flag high with code 00 below, ff above full scale, low in range.
// - Straight binary coding maps minus to plus full scale onto codes 0 to 255.
`timescale 1ns/100ps
module asp_sample_port #(
  parameter int STOP_CYCLES = asp_pkg::STOP_CYCLES,
  parameter int LATENCY = asp_pkg::LATENCY,
  parameter int WARM_CYCLES = asp_pkg::WARM_CYCLES,
  parameter int FIFO_DEPTH = asp_pkg::FIFO_DEPTH
) (
  input wire logic CLK_SYS, // System clock, 100 MHz
  input wire logic RST_B, // Synchronous reset, active low
  input wire logic CONV_CLK, // Conversion clock pin
  input wire logic POWER_DOWN_N, // Power-down pin, active low
  input wire logic signed [asp_pkg::AIN_W-1:0] AIN_DIFF, // Input difference, signed
  output logic [asp_pkg::DATA_W-1:0] DATA, // Parallel result code
  output logic RANGE_EXCEEDED_FLAG, // Over or underrange
  output logic DATA_VALID, // Warm-up complete
  output logic POWERED_DOWN, // Bias and amplifiers off
  output logic [$bits(asp_pkg::asp_result_t)-1:0] STRM_DATA, // Buffered result
  output logic STRM_VALID, // Buffered result present
  input wire logic STRM_READY, // Drain accepts result
  output logic STRM_ACCEPT // Buffer has room
);
  localparam int IW = $clog2(STOP_CYCLES + 1);
  localparam int WW = $clog2(WARM_CYCLES + 1);
  localparam logic [IW-1:0] STOP_CNT = IW'(STOP_CYCLES);
  localparam logic [WW-1:0] WARM_CNT = WW'(WARM_CYCLES);

  logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
  logic pd_s1_reg, pd_s2_reg;
  logic signed [asp_pkg::AIN_W-1:0] ain_s1_reg, ain_s2_reg, track_reg;
  logic pd_reg;
  logic [IW-1:0] idle_reg;
  logic [WW-1:0] warm_reg;
  asp_pkg::asp_result_t stage_reg [LATENCY];
  asp_pkg::asp_result_t out_reg;
  logic push_reg;
  logic fall;
  logic edge_seen;
  logic stopped;
  logic convert;

  function automatic asp_pkg::asp_result_t quantise(input logic signed [asp_pkg::AIN_W-1:0] v);
    asp_pkg::asp_result_t r;
    r.range_exceeded_flag = 1'b0;
    r.code = asp_pkg::CODE_MID + asp_pkg::DATA_W'(v);
    if (v < asp_pkg::AIN_NEG_FS) begin
      r.range_exceeded_flag = 1'b1;
      r.code = asp_pkg::CODE_MIN;
    end else if (v > asp_pkg::AIN_POS_FS) begin
      r.range_exceeded_flag = 1'b1;
      r.code = asp_pkg::CODE_MAX;
    end
    return r;
  endfunction

  // Pins cross into the system clock through two flops
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      // Idle level of the pin is high, so no false edge follows reset
      clk_s1_reg <= 1'b1;
      clk_s2_reg <= 1'b1;
      clk_s3_reg <= 1'b1;
      pd_s1_reg <= 1'b0;
      pd_s2_reg <= 1'b0;
      ain_s1_reg <= '0;
      ain_s2_reg <= '0;
    end else begin
      clk_s1_reg <= CONV_CLK;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      pd_s1_reg <= POWER_DOWN_N;
      pd_s2_reg <= pd_s1_reg;
      ain_s1_reg <= AIN_DIFF;
      ain_s2_reg <= ain_s1_reg;
    end
  end

  assign fall = clk_s3_reg && !clk_s2_reg;
  assign edge_seen = clk_s3_reg ^ clk_s2_reg;
  assign stopped = (idle_reg == STOP_CNT);
  assign convert = fall && !pd_reg;

  // Power-down state follows the synchronised pin
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      pd_reg <= 1'b1;
    end else begin
      pd_reg <= !pd_s2_reg;
    end
  end

  // Tracking only while clock is high and biased
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      track_reg <= '0;
    end else if (clk_s2_reg && !pd_reg) begin
      track_reg <= ain_s2_reg;
    end
  end

  // Five-deep pipeline; stage 0 is the fresh sample
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      for (int i = 0; i < LATENCY; i++) begin
        stage_reg[i] <= '0;
      end
    end else if (convert) begin
      stage_reg[0] <= quantise(track_reg);
      for (int i = 1; i < LATENCY; i++) begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end

  // Output holds between edges and through power-down
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      out_reg <= '0;
    end else if (convert) begin
      out_reg <= stage_reg[LATENCY-1];
    end
  end

  // Idle timer spots a stopped or too slow clock
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      idle_reg <= '0;
    end else if (edge_seen) begin
      idle_reg <= '0;
    end else if (!stopped) begin
      idle_reg <= idle_reg + 1'b1;
    end
  end

  // Reset holds warm-up at zero, as at power-up
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      warm_reg <= '0;
    end else if (pd_reg || stopped) begin
      warm_reg <= '0;
    end else if (fall && warm_reg != WARM_CNT) begin
      warm_reg <= warm_reg + 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      push_reg <= 1'b0;
    end else begin
      push_reg <= convert && (warm_reg == WARM_CNT);
    end
  end

  assign DATA = out_reg.code;
  assign RANGE_EXCEEDED_FLAG = out_reg.range_exceeded_flag;
  assign DATA_VALID = (warm_reg == WARM_CNT) && !pd_reg;
  assign POWERED_DOWN = pd_reg;

  // Words offered while full are dropped; STRM_ACCEPT shows when
  asp_fifo #(
    .WIDTH($bits(asp_pkg::asp_result_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .in_data(out_reg),
    .in_valid(push_reg),
    .in_ready(STRM_ACCEPT),
    .out_data(STRM_DATA),
    .out_valid(STRM_VALID),
    .out_ready(STRM_READY)
  );

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  a_track_window: assert property ($changed(track_reg) |-> $past(clk_s2_reg) && !$past(pd_reg))
    else $error("track changed outside high clock phase");
  a_sample_edge: assert property (convert |=> stage_reg[0] == quantise($past(track_reg)))
    else $error("falling edge did not capture tracked value");
  a_output_hold: assert property ($changed(out_reg) |-> $past(convert))
    else $error("output changed without a falling edge");
  a_pipe_shift: assert property (convert |=> out_reg == $past(stage_reg[LATENCY-1])
                                 && stage_reg[1] == $past(stage_reg[0]))
    else $error("pipeline did not advance on edge");
  a_stop_invalid: assert property (stopped |=> !DATA_VALID)
    else $error("data valid after clock stop");
  a_pd_no_conv: assert property (pd_reg |=> $stable(stage_reg[0]) && $stable(track_reg))
    else $error("conversion during power-down");
  a_pd_driven: assert property (pd_reg && POWERED_DOWN |=> DATA == $past(DATA)
                                && RANGE_EXCEEDED_FLAG == $past(RANGE_EXCEEDED_FLAG))
    else $error("outputs moved during power-down");
  a_wake_warm: assert property ($fell(pd_reg) |-> warm_reg == '0 ##0 !DATA_VALID [*2])
    else $error("valid too soon after power-down");
  a_range_code: assert property (stage_reg[0].range_exceeded_flag |->
                                 stage_reg[0].code == asp_pkg::CODE_MIN
                                 || stage_reg[0].code == asp_pkg::CODE_MAX)
    else $error("range flag with non-extreme code");
  a_code_mid: assert property (convert && track_reg == '0 |=> stage_reg[0].code == asp_pkg::CODE_MID
                               && !stage_reg[0].range_exceeded_flag)
    else $error("zero input not mid code");

  c_valid_rise: cover property ($rose(DATA_VALID));
  c_over_range: cover property (convert && track_reg > asp_pkg::AIN_POS_FS);
  c_pd_entry: cover property ($rose(pd_reg) ##[1:50] $fell(pd_reg));
  c_fifo_full: cover property (!STRM_ACCEPT);
endmodule

// >>> asp_host_model.sv
// Purpose: Host side, conversion clock source and result capture
// Assumes: Phases counted in system cycles
// Notes: Clock rests high between bursts, junk on input early in track
`timescale 1ns/100ps
module asp_host_model #(
  parameter int HALF = 6
) (
  input wire logic clk, // System clock
  input wire logic run, // Keep clocking
  input wire logic signed [asp_pkg::AIN_W-1:0] ain_in, // Next sample
  input wire logic [asp_pkg::DATA_W-1:0] data_in, // Converter code
  input wire logic flag_in, // Converter range flag
  output logic conv_clk, // Conversion clock
  output logic signed [asp_pkg::AIN_W-1:0] ain_out, // Input difference
  output logic done, // Capture strobe
  output asp_pkg::asp_result_t cap // Captured word
);
  int ph = 0;
  int nxt;
  initial begin
    conv_clk = 1'b1;
    ain_out = '0;
    done = 1'b0;
    cap = '0;
  end
  always @(posedge clk) begin
    done <= 1'b0;
    if (ph != 0 || run) begin
      nxt = (ph == 2 * HALF - 1) ? 0 : ph + 1;
      ph <= nxt;
      conv_clk <= (nxt < HALF);
      ain_out <= (nxt == 0) ? ~ain_in : ain_in;
      if (nxt == 2 * HALF - 1) begin
        cap <= {flag_in, data_in};
        done <= 1'b1;
      end
    end
  end
endmodule

// >>> testbench.sv
// Purpose: Self-checking bench for the sampling converter port
// Assumes: Host model paces the conversion clock
// Notes: Idle limit shortened so clock stops stay brief
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module testbench;
  localparam int STOP_N = 50;
  localparam int LAT = asp_pkg::LATENCY;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic pd_n = 1'b1;
  logic run = 1'b0;
  logic ready = 1'b1;
  logic signed [asp_pkg::AIN_W-1:0] ain = '0;
  logic signed [asp_pkg::AIN_W-1:0] ain_pin;
  logic conv_clk, flag, dvalid, pdown, svalid, saccept, done;
  logic [asp_pkg::DATA_W-1:0] data;
  asp_pkg::asp_result_t sdata, cap;
  asp_pkg::asp_result_t hist[$];
  asp_pkg::asp_result_t fifo_q[$];
  int err_total = 0;
  int cmp_count = 0;
  asp_sample_port #(.STOP_CYCLES(STOP_N)) dut_u (.CLK_SYS(clk), .RST_B(rst_b), .CONV_CLK(conv_clk),
    .POWER_DOWN_N(pd_n), .AIN_DIFF(ain_pin), .DATA(data), .RANGE_EXCEEDED_FLAG(flag), .DATA_VALID(dvalid),
    .POWERED_DOWN(pdown), .STRM_DATA(sdata), .STRM_VALID(svalid), .STRM_READY(ready), .STRM_ACCEPT(saccept));
  asp_host_model host_u (.clk(clk), .run(run), .ain_in(ain), .data_in(data), .flag_in(flag),
    .conv_clk(conv_clk), .ain_out(ain_pin), .done(done), .cap(cap));
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic asp_pkg::asp_result_t expect_word(input logic signed [asp_pkg::AIN_W-1:0] v);
    if (v < asp_pkg::AIN_NEG_FS) return {1'b1, asp_pkg::CODE_MIN};
    if (v > asp_pkg::AIN_POS_FS) return {1'b1, asp_pkg::CODE_MAX};
    return {1'b0, asp_pkg::DATA_W'(v + 10'sd128)};
  endfunction
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One conversion clock period, result captured late in low phase
  task automatic period(input logic signed [asp_pkg::AIN_W-1:0] v, input bit chk);
    int n;
    n = 0;
    ain = v;
    run = 1'b1;
    @(negedge clk);
    while (done !== 1'b1) begin
      n++;
      if (n > 40) begin
        err_total++;
        print_verdict();
      end
      @(negedge clk);
    end
    run = 1'b0;
    // Let the wrap edge pass so a following call never re-raises run in this step
    @(negedge clk);
    hist.push_back(expect_word(v));
    if (chk && hist.size() > LAT) `CHK("result", hist[hist.size() - 1 - LAT], cap)
  endtask
  task automatic warm_up();
    hist.delete();
    for (int i = 1; i <= asp_pkg::WARM_CYCLES; i++) begin
      period(10'sd0, 1'b0);
      if (i == asp_pkg::WARM_CYCLES - 1) `CHK("valid early", 1'b0, dvalid)
    end
    `CHK("valid after warm-up", 1'b1, dvalid)
  endtask
  // Edge codes and clipping, FIFO held off so it fills and refuses
  task automatic table_run();
    logic signed [asp_pkg::AIN_W-1:0] vals[15] = '{-10'sd300, -10'sd129, -10'sd128, -10'sd1, 10'sd0,
      10'sd1, 10'sd127, 10'sd128, 10'sd5, -10'sd60, 10'sd0, 10'sd0, 10'sd0, 10'sd0, 10'sd0};
    for (int i = 0; i < 15; i++) begin
      period(vals[i], 1'b1);
      if (fifo_q.size() < 4) fifo_q.push_back(cap);
    end
    `CHK("fifo full", 1'b0, saccept)
    ready = 1'b1;
    for (int i = 0; i < 4; i++) begin
      `CHK("stream word", fifo_q[i], sdata)
      @(negedge clk);
    end
    `CHK("stream empty", 1'b0, svalid)
  endtask
  task automatic clock_stop(input int idle, input logic exp);
    repeat (idle) @(negedge clk);
    `CHK("valid after stop", exp, dvalid)
  endtask
  task automatic power_down();
    asp_pkg::asp_result_t held;
    held = {flag, data};
    pd_n = 1'b0;
    repeat (6) @(negedge clk);
    `CHK("asleep", 2'b10, {pdown, dvalid})
    for (int i = 0; i < 3; i++) period(10'sd200, 1'b0);
    `CHK("held word", held, {flag, data})
    `CHK("no stream", 1'b0, svalid)
    pd_n = 1'b1;
    warm_up();
  endtask
  initial begin
    repeat (3) @(negedge clk);
    `CHK("reset outputs", 13'h005, {data, flag, dvalid, pdown, svalid, saccept})
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    `CHK("awake", 1'b0, pdown)
    warm_up();
    repeat (4) @(negedge clk);
    ready = 1'b0;
    table_run();
    clock_stop(30, 1'b1);
    period(10'sd0, 1'b0);
    clock_stop(STOP_N + 20, 1'b0);
    power_down();
    print_verdict();
  end
endmodule
